// >>> pkg/dpm_pkg.sv
// package: constants and carriers of the code point priority map
package dpm_pkg;

   // bus and table geometry
   localparam int ADDR_W         = 8;
   localparam int DATA_W         = 8;
   localparam int PRIO_W         = 2;
   localparam int CODE_W         = 6;
   localparam int NUM_CODES      = 64;
   localparam int TABLE_W        = 128;
   localparam int NUM_REGS       = 16;
   localparam int REG_IDX_W      = 4;
   localparam int FIELD_IDX_W    = 2;

   // code point position inside the type-of-service byte
   localparam int CODE_MSB       = 7;
   localparam int CODE_LSB       = 2;

   // register offsets; the table block is aligned to sixteen bytes
   localparam logic [ADDR_W-1:0] OFS_MAP_BASE                    = 8'h60;
   localparam logic [ADDR_W-1:0] OFS_IP_PRIORITY_MAP_CODES_0C_0F = 8'h63;
   localparam logic [ADDR_W-1:0] OFS_IP_PRIORITY_MAP_CODES_10_13 = 8'h64;
   localparam logic [ADDR_W-1:0] OFS_IP_PRIORITY_MAP_CODES_14_17 = 8'h65;
   localparam logic [ADDR_W-1:0] OFS_IP_PRIORITY_MAP_CODES_18_1B = 8'h66;
   localparam logic [ADDR_W-1:0] OFS_IP_PRIORITY_MAP_CODES_1C_1F = 8'h67;
   localparam logic [ADDR_W-1:0] OFS_IP_PRIORITY_MAP_CODES_20_23 = 8'h68;
   localparam logic [ADDR_W-1:0] OFS_IP_PRIORITY_MAP_CODES_24_27 = 8'h69;
   localparam logic [ADDR_W-1:0] OFS_IP_PRIORITY_MAP_CODES_28_2B = 8'h6a;

   // reset and read values
   localparam logic [DATA_W-1:0] MAP_RESET      = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;
   localparam logic [PRIO_W-1:0] PRIO_RESET     = 2'h0;
   localparam logic [CODE_W-1:0] CODE_RESET     = 6'h00;

   // register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } dpm_bus_req_t;

   // lookup request from frame classification
   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] tos;
   } dpm_lkup_req_t;

   // lookup answer, one cycle after the request
   typedef struct packed {
      logic              valid;
      logic [CODE_W-1:0] code;
      logic [PRIO_W-1:0] prio;
   } dpm_lkup_rsp_t;

endpackage : dpm_pkg

// >>> verilog/dpm_map_reg.sv
// one eight-bit register of the priority table, four two-bit fields
`timescale 1ns/1ps
`default_nettype none

module dpm_map_reg (
   input  wire logic                        mclk,
   input  wire logic                        resetn,
   input  wire logic                        wr_en,
   input  wire logic [dpm_pkg::DATA_W-1:0]  wdata,
   output logic      [dpm_pkg::DATA_W-1:0]  value,
   output logic      [dpm_pkg::DATA_W-1:0]  value_nxt
);

   logic [dpm_pkg::DATA_W-1:0] value_r;

   // next value is exposed so a lookup in the write cycle sees the new field
   always_comb begin
      value_nxt = wr_en ? wdata : value_r;
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         value_r <= dpm_pkg::MAP_RESET;
      end else begin
         value_r <= value_nxt;
      end
   end

   assign value = value_r;

   field_write_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      wr_en |=> value == $past(wdata)
   ) else $error("table register did not take the written value");

   field_hold_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      !wr_en |=> $stable(value)
   ) else $error("table register changed without a write");

endmodule : dpm_map_reg

`default_nettype wire

// >>> verilog/dpm_priority_map.sv
// code point to frame priority table with register port and lookup port
//
// How it works
// - priority comes from the table field chosen by tos bits 7 to 2
// - codes 0x0c to 0x0e use bits 1-0, 3-2, 5-4 of register 0x63
// - codes 0x10 to 0x13 use fields 1-0 to 7-6 of register 0x64
// - codes 0x14 to 0x17 use fields 1-0 to 7-6 of register 0x65
// - codes 0x18 to 0x1b use fields 1-0 to 7-6 of register 0x66
// - codes 0x1c to 0x1f use fields 1-0 to 7-6 of register 0x67
// - codes 0x20 to 0x23 use fields 1-0 to 7-6 of register 0x68
// - codes 0x24 to 0x27 use fields 1-0 to 7-6 of register 0x69
// - codes 0x28 to 0x2b use fields 1-0 to 7-6 of register 0x6a
// - all 64 codes decode into a 128-bit table, two bits per code
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module dpm_priority_map (
   input  wire logic                           mclk,
   input  wire logic                           resetn,
   input  wire dpm_pkg::dpm_bus_req_t          bus_req,
   output logic      [dpm_pkg::DATA_W-1:0]     rdata,
   input  wire dpm_pkg::dpm_lkup_req_t         lkup_req,
   output var  dpm_pkg::dpm_lkup_rsp_t         lkup_rsp
);

   // register file state
   logic [dpm_pkg::DATA_W-1:0]    map_q   [dpm_pkg::NUM_REGS];
   logic [dpm_pkg::DATA_W-1:0]    map_nxt [dpm_pkg::NUM_REGS];
   logic [dpm_pkg::TABLE_W-1:0]   table_q;
   logic [dpm_pkg::TABLE_W-1:0]   table_nxt;

   // bus decode
   logic                          map_hit;
   logic [dpm_pkg::REG_IDX_W-1:0] reg_idx;
   logic [dpm_pkg::DATA_W-1:0]    rdata_r;

   // lookup path
   logic [dpm_pkg::CODE_W-1:0]    code;
   logic [dpm_pkg::PRIO_W-1:0]    prio_nxt;
   logic                          rsp_valid_r;
   logic [dpm_pkg::CODE_W-1:0]    rsp_code_r;
   logic [dpm_pkg::PRIO_W-1:0]    rsp_prio_r;

   // the whole 0x60-0x6f block is one aligned group of sixteen
   assign map_hit = bus_req.addr[dpm_pkg::ADDR_W-1:dpm_pkg::REG_IDX_W]
                    == dpm_pkg::OFS_MAP_BASE[dpm_pkg::ADDR_W-1:dpm_pkg::REG_IDX_W];
   assign reg_idx = bus_req.addr[dpm_pkg::REG_IDX_W-1:0];

   genvar gi;
   generate
      for (gi = 0; gi < dpm_pkg::NUM_REGS; gi++) begin : g_reg
         dpm_map_reg u_reg (
            .mclk      (mclk),
            .resetn    (resetn),
            .wr_en     (bus_req.wr && map_hit && (int'(reg_idx) == gi)),
            .wdata     (bus_req.wdata),
            .value     (map_q[gi]),
            .value_nxt (map_nxt[gi])
         );
         assign table_q[gi*dpm_pkg::DATA_W +: dpm_pkg::DATA_W]   = map_q[gi];
         assign table_nxt[gi*dpm_pkg::DATA_W +: dpm_pkg::DATA_W] = map_nxt[gi];
      end
   endgenerate

   // read back; unmapped reads give zero, writes there are dropped
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rdata_r <= dpm_pkg::RDATA_UNMAPPED;
      end else if (bus_req.rd) begin
         rdata_r <= map_hit ? map_q[reg_idx] : dpm_pkg::RDATA_UNMAPPED;
      end
   end

   assign rdata = rdata_r;

   // code point from type-of-service bits 7 to 2
   assign code = lkup_req.tos[dpm_pkg::CODE_MSB:dpm_pkg::CODE_LSB];

   // full decode into the flat table
   // next-state table so a same-cycle write is not missed
   assign prio_nxt = table_nxt[int'(code) * dpm_pkg::PRIO_W +: dpm_pkg::PRIO_W];

   // answer registered: costs one cycle, keeps the output glitch free
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rsp_valid_r <= 1'b0;
      end else begin
         rsp_valid_r <= lkup_req.valid;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rsp_code_r <= dpm_pkg::CODE_RESET;
         rsp_prio_r <= dpm_pkg::PRIO_RESET;
      end else if (lkup_req.valid) begin
         rsp_code_r <= code;
         rsp_prio_r <= prio_nxt;
      end
   end

   assign lkup_rsp.valid = rsp_valid_r;
   assign lkup_rsp.code  = rsp_code_r;
   assign lkup_rsp.prio  = rsp_prio_r;

   // checking helpers
   function automatic logic [dpm_pkg::PRIO_W-1:0] pick_field(
      input logic [dpm_pkg::DATA_W-1:0]      r,
      input logic [dpm_pkg::FIELD_IDX_W-1:0] f
   );
      logic [dpm_pkg::PRIO_W-1:0] p;
      p = r[1:0];
      unique case (f)
         2'h0: p = r[1:0];
         2'h1: p = r[3:2];
         2'h2: p = r[5:4];
         2'h3: p = r[7:6];
      endcase
      return p;
   endfunction : pick_field

   function automatic int reg_of(input logic [dpm_pkg::ADDR_W-1:0] ofs);
      return int'(ofs - dpm_pkg::OFS_MAP_BASE);
   endfunction : reg_of

   // checking model: a second copy of the table fed from the bus alone
   logic [dpm_pkg::DATA_W-1:0]    ref_r [dpm_pkg::NUM_REGS];

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         for (int i = 0; i < dpm_pkg::NUM_REGS; i++) begin
            ref_r[i] <= dpm_pkg::MAP_RESET;
         end
      end else if (bus_req.wr
                   && bus_req.addr[dpm_pkg::ADDR_W-1:dpm_pkg::REG_IDX_W]
                      == dpm_pkg::OFS_MAP_BASE[dpm_pkg::ADDR_W-1:dpm_pkg::REG_IDX_W]) begin
         ref_r[bus_req.addr[dpm_pkg::REG_IDX_W-1:0]] <= bus_req.wdata;
      end
   end

   // a register's four codes map to its four fields in order
   property grp_map_p(logic [dpm_pkg::ADDR_W-1:0] ofs);
      @(posedge mclk) disable iff (!resetn)
      lkup_req.valid && (int'(code[dpm_pkg::CODE_W-1:dpm_pkg::FIELD_IDX_W]) == reg_of(ofs))
      |=> lkup_rsp.valid
          && lkup_rsp.prio == pick_field($past(map_nxt[reg_of(ofs)]),
                                         $past(code[dpm_pkg::FIELD_IDX_W-1:0]));
   endproperty

   code_field_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      lkup_req.valid |=> lkup_rsp.valid && lkup_rsp.code == $past(lkup_req.tos[7:2])
   ) else $error("answer code is not tos bits 7 to 2");

   code_ignore_low_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      lkup_req.valid ##1 lkup_req.valid
      && lkup_req.tos[7:2] == $past(lkup_req.tos[7:2])
      && !$past(bus_req.wr) && !bus_req.wr
      |=> lkup_rsp.prio == $past(lkup_rsp.prio)
   ) else $error("tos bits 1 to 0 changed the priority");

   codes_0c_0e_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      lkup_req.valid && code inside {6'h0c, 6'h0d, 6'h0e}
      |=> (($past(code) == 6'h0c) && lkup_rsp.prio == $past(map_nxt[3][1:0]))
       || (($past(code) == 6'h0d) && lkup_rsp.prio == $past(map_nxt[3][3:2]))
       || (($past(code) == 6'h0e) && lkup_rsp.prio == $past(map_nxt[3][5:4]))
   ) else $error("codes 0x0c to 0x0e use wrong field of register 0x63");

   codes_10_13_a : assert property (
      grp_map_p(dpm_pkg::OFS_IP_PRIORITY_MAP_CODES_10_13)
   ) else $error("codes 0x10 to 0x13 use wrong field");

   codes_14_17_a : assert property (
      grp_map_p(dpm_pkg::OFS_IP_PRIORITY_MAP_CODES_14_17)
   ) else $error("codes 0x14 to 0x17 use wrong field");

   codes_18_1b_a : assert property (
      grp_map_p(dpm_pkg::OFS_IP_PRIORITY_MAP_CODES_18_1B)
   ) else $error("codes 0x18 to 0x1b use wrong field");

   codes_1c_1f_a : assert property (
      grp_map_p(dpm_pkg::OFS_IP_PRIORITY_MAP_CODES_1C_1F)
   ) else $error("codes 0x1c to 0x1f use wrong field");

   codes_20_23_a : assert property (
      grp_map_p(dpm_pkg::OFS_IP_PRIORITY_MAP_CODES_20_23)
   ) else $error("codes 0x20 to 0x23 use wrong field");

   codes_24_27_a : assert property (
      grp_map_p(dpm_pkg::OFS_IP_PRIORITY_MAP_CODES_24_27)
   ) else $error("codes 0x24 to 0x27 use wrong field");

   codes_28_2b_a : assert property (
      grp_map_p(dpm_pkg::OFS_IP_PRIORITY_MAP_CODES_28_2B)
   ) else $error("codes 0x28 to 0x2b use wrong field");

   // independent spot check: a write to 0x64 then code 0x13 gives bits 7-6
   write_then_lookup_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      bus_req.wr && bus_req.addr == 8'h64 ##1 lkup_req.valid && code == 6'h13 && !bus_req.wr
      |=> lkup_rsp.prio == $past(bus_req.wdata[7:6], 2)
   ) else $error("code 0x13 does not follow register 0x64 bits 7-6");

   full_table_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      lkup_req.valid && !bus_req.wr
      |=> lkup_rsp.prio == $past(table_q[2*int'(code) +: 2])
   ) else $error("priority is not the table pair of the code");

   same_cycle_write_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      lkup_req.valid && bus_req.wr && map_hit
      && bus_req.addr[3:0] == code[5:2]
      |=> lkup_rsp.prio == pick_field($past(bus_req.wdata), $past(code[1:0]))
   ) else $error("lookup missed the field written in the same cycle");

   property write_read_p;
      logic [dpm_pkg::DATA_W-1:0] d;
      logic [dpm_pkg::ADDR_W-1:0] a;
      @(posedge mclk) disable iff (!resetn)
      (bus_req.wr && map_hit, d = bus_req.wdata, a = bus_req.addr)
      ##1 (bus_req.rd && bus_req.addr == a)
      |=> rdata == d;
   endproperty

   write_read_a : assert property (
      write_read_p
   ) else $error("read did not return the last written value");

   unmapped_read_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      bus_req.rd && !map_hit |=> rdata == 8'h00
   ) else $error("unmapped read did not return zero");

   reset_clear_a : assert property (
      @(posedge mclk)
      !resetn |=> table_q == '0 && !lkup_rsp.valid
   ) else $error("table or answer not cleared by reset");

   rsp_only_after_req_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      !lkup_req.valid |=> !lkup_rsp.valid
   ) else $error("answer without a request");

   rsp_hold_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      !lkup_req.valid |=> $stable(lkup_rsp.code) && $stable(lkup_rsp.prio)
   ) else $error("answer changed without a request");

   back_to_back_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      lkup_req.valid ##1 lkup_req.valid |=> lkup_rsp.valid && lkup_rsp.code == $past(code)
   ) else $error("back-to-back answer out of order");

   rdata_hold_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      !bus_req.rd |=> $stable(rdata)
   ) else $error("read data changed without a read");

   table_hold_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      !bus_req.wr |=> $stable(table_q)
   ) else $error("table changed without a write");

   unmapped_write_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      bus_req.wr && !map_hit |=> $stable(table_q)
   ) else $error("unmapped write changed the table");

   // a mapped write lands in its byte
   write_lands_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      bus_req.wr && map_hit
      |=> table_q[int'($past(reg_idx)) * dpm_pkg::DATA_W +: dpm_pkg::DATA_W] == $past(bus_req.wdata)
   ) else $error("written byte did not land in the table");

   // a write elsewhere leaves the lookup alone
   other_write_a : assert property (
      @(posedge mclk) disable iff (!resetn)
      lkup_req.valid && bus_req.wr && map_hit && reg_idx != code[dpm_pkg::CODE_W-1:dpm_pkg::FIELD_IDX_W]
      |=> lkup_rsp.prio == $past(table_q[int'(code) * dpm_pkg::PRIO_W +: dpm_pkg::PRIO_W])
   ) else $error("a write to another register changed the answer");

   reset_outputs_a : assert property (
      @(posedge mclk)
      !resetn |=> rdata == dpm_pkg::RDATA_UNMAPPED && lkup_rsp.code == dpm_pkg::CODE_RESET
                  && lkup_rsp.prio == dpm_pkg::PRIO_RESET
   ) else $error("outputs not cleared by reset");

   // every table byte serves its own four codes
   for (gi = 0; gi < dpm_pkg::NUM_REGS; gi++) begin : g_chk
      table_byte_a : assert property (
         @(posedge mclk) disable iff (!resetn)
         lkup_req.valid && !bus_req.wr && int'(code[dpm_pkg::CODE_W-1:dpm_pkg::FIELD_IDX_W]) == gi
         |=> lkup_rsp.prio == pick_field($past(ref_r[gi]), $past(code[dpm_pkg::FIELD_IDX_W-1:0]))
      ) else $error("a code did not use its own table byte");

      reg_read_a : assert property (
         @(posedge mclk) disable iff (!resetn)
         bus_req.rd && map_hit && int'(reg_idx) == gi |=> rdata == $past(ref_r[gi])
      ) else $error("read did not return its register");

      ref_match_a : assert property (
         @(posedge mclk) disable iff (!resetn)
         map_q[gi] == ref_r[gi]
      ) else $error("a table register differs from the bus history");

      reg_reset_a : assert property (
         @(posedge mclk)
         !resetn |=> map_q[gi] == dpm_pkg::MAP_RESET
      ) else $error("a table register was not cleared by reset");
   end

   // main scenarios
   lookup_0c_c : cover property (
      @(posedge mclk) disable iff (!resetn)
      lkup_req.valid && code == 6'h0c ##1 lkup_rsp.prio != 2'h0
   );

   lookup_2b_c : cover property (
      @(posedge mclk) disable iff (!resetn)
      bus_req.wr && bus_req.addr == 8'h6a ##[1:20] lkup_req.valid && code == 6'h2b
   );

   same_cycle_c : cover property (
      @(posedge mclk) disable iff (!resetn)
      lkup_req.valid && bus_req.wr && map_hit && bus_req.addr[3:0] == code[5:2]
   );

   back_to_back_c : cover property (
      @(posedge mclk) disable iff (!resetn)
      lkup_req.valid [*3] ##1 lkup_rsp.valid
   );

   unmapped_read_c : cover property (
      @(posedge mclk) disable iff (!resetn)
      bus_req.rd && !map_hit
   );

endmodule : dpm_priority_map

`default_nettype wire

// >>> test/dpm_classifier_model.sv
// far side model: frame classification logic presenting lookup requests
`timescale 1ns/1ps
`default_nettype none

module dpm_classifier_model (
   input  wire logic                       mclk,
   input  wire logic                       cmd_valid,
   input  wire logic [dpm_pkg::DATA_W-1:0] cmd_tos,
   output var  dpm_pkg::dpm_lkup_req_t     lkup_req
);
   logic [dpm_pkg::DATA_W-1:0] last_r = 8'h00;

   // idle tos lines flip every cycle so a design that ignores valid shows up
   always_ff @(posedge mclk) begin
      last_r <= lkup_req.tos;
   end

   assign lkup_req = {cmd_valid, (cmd_valid ? cmd_tos : ~last_r)};
endmodule : dpm_classifier_model
`default_nettype wire

// >>> test/tb.sv
// testbench: register port and lookup port of the priority map
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic                       mclk;
   logic                       resetn;
   dpm_pkg::dpm_bus_req_t      bus_req;
   logic [dpm_pkg::DATA_W-1:0] rdata;
   dpm_pkg::dpm_lkup_req_t     lkup_req;
   dpm_pkg::dpm_lkup_rsp_t     lkup_rsp;
   logic                       cmd_valid;
   logic [dpm_pkg::DATA_W-1:0] cmd_tos;
   logic [7:0]                 shadow [16];
   logic [7:0]                 tbl [16];
   logic [7:0]                 exp_q [$];
   logic [7:0]                 e;
   logic [5:0]                 c;
   int                         err_total;
   int                         n_compared;

   dpm_priority_map DUT (.mclk(mclk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
                         .lkup_req(lkup_req), .lkup_rsp(lkup_rsp));
   dpm_classifier_model model (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_tos(cmd_tos), .lkup_req(lkup_req));

   always #50 mclk = ~mclk;

   task automatic report(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : report
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      report(got, exp);
   endtask : chk_byte
   task automatic chk_code(input logic [5:0] got, input logic [5:0] exp);
      report({2'h0, got}, {2'h0, exp});
   endtask : chk_code
   task automatic chk_prio(input logic [1:0] got, input logic [1:0] exp);
      report({6'h00, got}, {6'h00, exp});
   endtask : chk_prio

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   function automatic logic [7:0] pat(input int n);
      return 8'(n * 8'h53 + 8'h2d);
   endfunction : pat

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus_req.wr    <= 1'b1;
      bus_req.addr  <= a;
      bus_req.wdata <= d;
      @(posedge mclk);
      bus_req.wr <= 1'b0;
      if (a[7:4] == 4'h6) shadow[a[3:0]] = d;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a);
      logic [7:0] x;
      // unmapped places read back as zero
      x = (a[7:4] == 4'h6) ? shadow[a[3:0]] : 8'h00;
      @(posedge mclk);
      bus_req.rd   <= 1'b1;
      bus_req.addr <= a;
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      @(negedge mclk);
      chk_byte(rdata, x);
   endtask : rd_chk

   // back-to-back lookups; low tos bits vary since they must be ignored
   task automatic look_range(input logic [5:0] first, input int cnt);
      for (int i = 0; i < cnt; i++) begin
         @(posedge mclk);
         cmd_valid <= 1'b1;
         cmd_tos   <= {first + 6'(i), ~(first[1:0] + 2'(i))};
      end
      @(posedge mclk);
      cmd_valid <= 1'b0;
      @(posedge mclk);
   endtask : look_range

   task automatic wr_look(input logic [7:0] a, input logic [7:0] d, input logic [5:0] code);
      @(posedge mclk);
      bus_req.wr    <= 1'b1;
      bus_req.addr  <= a;
      bus_req.wdata <= d;
      cmd_valid     <= 1'b1;
      cmd_tos       <= {code, 2'h2};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
      cmd_valid  <= 1'b0;
      shadow[a[3:0]] = d;
      @(posedge mclk);
   endtask : wr_look

   // write, read back at once with the first of two lookups that differ only in low tos bits
   task automatic wr_rd_look(input logic [7:0] a, input logic [7:0] d, input logic [5:0] code);
      @(posedge mclk);
      bus_req.wr    <= 1'b1;
      bus_req.addr  <= a;
      bus_req.wdata <= d;
      @(posedge mclk);
      bus_req.wr <= 1'b0;
      bus_req.rd <= 1'b1;
      cmd_valid  <= 1'b1;
      cmd_tos    <= {code, 2'h0};
      if (a[7:4] == 4'h6) shadow[a[3:0]] = d;
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      cmd_tos    <= {code, 2'h3};
      @(negedge mclk);
      chk_byte(rdata, d);
      @(posedge mclk);
      cmd_valid <= 1'b0;
      @(posedge mclk);
   endtask : wr_rd_look

   task automatic do_reset(input int n);
      resetn <= 1'b0;
      repeat (n) @(posedge mclk);
      resetn <= 1'b1;
      foreach (shadow[i]) shadow[i] = 8'h00;
   endtask : do_reset

   // answer one cycle after request, field chosen by tos bits 7 to 2
   always @(negedge mclk) begin
      if (lkup_rsp.valid === 1'b1) begin
         if (exp_q.size() == 0) chk_byte(8'h01, 8'h00);
         else begin
            e = exp_q.pop_front();
            chk_code(lkup_rsp.code, e[7:2]);
            chk_prio(lkup_rsp.prio, e[1:0]);
         end
      end
      if (lkup_req.valid === 1'b1 && resetn === 1'b1) begin
         tbl = shadow;
         // a write taken at the same edge is already seen by the lookup
         if (bus_req.wr && bus_req.addr[7:4] == 4'h6) tbl[bus_req.addr[3:0]] = bus_req.wdata;
         c = lkup_req.tos[7:2];
         exp_q.push_back({c, tbl[c[5:2]][2*c[1:0] +: 2]});
      end
   end

   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      print_verdict();
   end

   initial begin
      mclk       = 1'b0;
      resetn     = 1'b0;
      bus_req    = '0;
      cmd_valid  = 1'b0;
      cmd_tos    = 8'h00;
      err_total  = 0;
      n_compared = 0;
      foreach (shadow[i]) shadow[i] = 8'h00;
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      for (int n = 0; n < 16; n++) rd_chk(8'h60 + 8'(n));
      look_range(6'h00, 64);
      for (int n = 0; n < 16; n++) wr(8'h60 + 8'(n), pat(n));
      wr(8'h70, 8'hff);
      wr(8'h5f, 8'hff);
      rd_chk(8'h70);
      rd_chk(8'h5f);
      for (int n = 0; n < 16; n++) rd_chk(8'h60 + 8'(n));
      look_range(6'h0c, 3);
      look_range(6'h10, 4);
      look_range(6'h14, 4);
      look_range(6'h18, 4);
      look_range(6'h1c, 4);
      look_range(6'h20, 4);
      look_range(6'h24, 4);
      look_range(6'h28, 4);
      look_range(6'h00, 64);
      wr_look(8'h66, ~pat(6), 6'h19);
      wr_look(8'h6a, ~pat(10), 6'h2b);
      wr_look(8'h65, ~pat(5), 6'h19);
      wr_rd_look(8'h64, 8'h9c, 6'h13);
      // a second reset mid-run clears every field again
      do_reset(2);
      rd_chk(8'h64);
      rd_chk(8'h6a);
      look_range(6'h10, 4);
      chk_byte(8'(exp_q.size()), 8'h00);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
